// [hdl/pwr_switch_pkg.sv]
// constants and types shared by the socket power switch serial port
package pwr_switch_pkg;
    // ***********************************************************
    // frame layout
    // ***********************************************************
    localparam int SOCKET_BITS  = 4;
    localparam int FRAME_BITS   = 2 * SOCKET_BITS;
    localparam int CNT_W        = 4;
    // ***********************************************************
    // control bit positions
    // ***********************************************************
    localparam int OSC_EN_BIT   = 27;
    localparam logic [7:0] SYS_CTRL_OFFSET = 8'h80;
    // ***********************************************************
    // ring oscillator half period in clock cycles
    // ***********************************************************
    localparam int OSC_HALF_NS  = 160;
    localparam int CLK_NS       = 40;
    localparam int OSC_HALF_CYC = (OSC_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] OSC_HALF_CNT = 8'(OSC_HALF_CYC);
    // ***********************************************************
    // states
    // ***********************************************************
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_LATCH = 2'b10
    } shift_state_t;
endpackage

// [hdl/shift_clk_if.sv]
// interface carrying shift clock edges between oscillator and shifter
`timescale 1ns/10ps
interface shift_clk_if;
    logic rise;
    logic fall;
    logic run;
    modport src (output rise, output fall, input run);
    modport dst (input rise, input fall, output run);
endinterface

// [hdl/shift_clk_gen.sv]
// shift clock edge source: external pin sampler or internal oscillator
`timescale 1ns/10ps
module shift_clk_gen
    import pwr_switch_pkg::*;
(
    input  wire logic   i_clk,
    input  wire logic   i_rst,
    input  wire logic   i_osc_en,
    input  wire logic   i_clk_pin,
    output logic        o_clk_drv,
    shift_clk_if.src    edges
);
    logic       sync1_r;
    logic       sync2_r;
    logic       prev_r;
    logic [7:0] cnt_r;
    logic       osc_r;
    logic       lvl;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= i_clk_pin;
            sync2_r <= sync1_r;
        end
    end

    // oscillator runs only while a frame wants edges
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_osc_en || !edges.run) begin
            cnt_r <= 8'h00;
            osc_r <= 1'b0;
        end else if (cnt_r == OSC_HALF_CNT - 8'h01) begin
            cnt_r <= 8'h00;
            osc_r <= ~osc_r;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    assign lvl = i_osc_en ? osc_r : sync2_r; // (R2) (R3)

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= lvl;
        end
    end

    assign edges.rise = lvl & ~prev_r;
    assign edges.fall = ~lvl & prev_r;
    assign o_clk_drv  = osc_r;
endmodule

// [hdl/pwr_switch_port.sv]
// three line serial port toward the dual socket power switch
//
// What this block does
// (R1) data changes on shift clock fall so it is stable at each rise
// (R2) after a reset without suspend the clock pin is an input fed from outside
// (R3) oscillator enable bit makes the block drive its own shift clock
// (R4) socket power settings leave one bit per shift clock period
// (R5) latch pulses only after the whole frame has been shifted
// (R6) any change of a socket request starts a new two-socket frame
// (R7) reset clears all state; suspend keeps everything except the shift clock generator registers
`timescale 1ns/10ps
module pwr_switch_port
    import pwr_switch_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    input  wire logic                   i_suspend,
    input  wire logic                   i_osc_en_wr,
    input  wire logic                   i_osc_en_val,
    input  wire logic [SOCKET_BITS-1:0] i_sock_a,
    input  wire logic [SOCKET_BITS-1:0] i_sock_b,
    input  wire logic                   i_clock_in,
    output logic                        o_clock_out,
    output logic                        o_clock_oe,
    output logic                        o_data,
    output logic                        o_latch,
    output logic                        o_busy
);
    // ***********************************************************
    // state
    // ***********************************************************
    shift_clk_if                 edges ();
    shift_state_t                state_r;
    logic                        osc_en_r;
    logic [FRAME_BITS-1:0]       req_r;
    logic [FRAME_BITS-1:0]       sent_r;
    logic [FRAME_BITS-1:0]       sh_r;
    logic [CNT_W-1:0]            cnt_r;
    logic                        pend_r;
    logic                        data_r;
    logic                        latch_r;
    logic                        clk_drv;
    logic                        hold;

    // suspend shields state from reset
    assign hold = i_rst & ~i_suspend; // (R7)

    always_ff @(posedge i_clk) begin
        if (hold) begin
            osc_en_r <= 1'b0; // (R2) (R7)
        end else if (i_osc_en_wr) begin
            osc_en_r <= i_osc_en_val; // (R3)
        end
    end

    shift_clk_gen u_gen (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_osc_en  (osc_en_r),
        .i_clk_pin (i_clock_in),
        .o_clk_drv (clk_drv),
        .edges     (edges)
    );

    assign edges.run = (state_r == ST_SHIFT);

    // ***********************************************************
    // request tracking
    // ***********************************************************
    always_ff @(posedge i_clk) begin
        if (hold) begin
            req_r  <= '0;
            pend_r <= 1'b0;
        end else begin
            req_r <= {i_sock_b, i_sock_a};
            // a change during a frame is kept and sent next
            if ({i_sock_b, i_sock_a} != sent_r) begin
                pend_r <= 1'b1; // (R6)
            end else if (state_r == ST_IDLE) begin
                pend_r <= 1'b0;
            end
        end
    end

    // ***********************************************************
    // shifter
    // ***********************************************************
    always_ff @(posedge i_clk) begin
        if (hold) begin
            state_r <= ST_IDLE;
            sent_r  <= '0;
            sh_r    <= '0;
            cnt_r   <= '0;
            data_r  <= 1'b0;
            latch_r <= 1'b0;
        end else begin
            latch_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (pend_r && req_r != sent_r) begin
                        sent_r  <= req_r; // (R6)
                        sh_r    <= req_r;
                        cnt_r   <= '0;
                        data_r  <= req_r[FRAME_BITS-1]; // (R1)
                        state_r <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (edges.rise) begin
                        cnt_r <= cnt_r + 1'b1; // (R4)
                        sh_r  <= {sh_r[FRAME_BITS-2:0], 1'b0};
                    end else if (edges.fall) begin
                        if (cnt_r == CNT_W'(FRAME_BITS)) begin
                            state_r <= ST_LATCH;
                        end else begin
                            data_r <= sh_r[FRAME_BITS-1]; // (R1) (R4)
                        end
                    end
                end
                ST_LATCH: begin
                    latch_r <= 1'b1; // (R5)
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign o_data      = data_r;
    assign o_latch     = latch_r;
    assign o_clock_out = clk_drv;
    assign o_clock_oe  = osc_en_r; // (R2) (R3)
    assign o_busy      = (state_r != ST_IDLE);

    // ***********************************************************
    // checks
    // ***********************************************************
    AST_LATCH_AFTER_FRAME: assert property ( // (R5)
        @(posedge i_clk) disable iff (i_rst)
        o_latch |-> $past(state_r) == ST_LATCH && $past(cnt_r) == CNT_W'(FRAME_BITS))
        else $error("latch without a complete frame");
    AST_LATCH_ONE_CYCLE: assert property ( // (R5)
        @(posedge i_clk) disable iff (i_rst)
        o_latch |=> !o_latch)
        else $error("latch longer than one cycle");
    AST_DATA_STABLE_RISE: assert property ( // (R1)
        @(posedge i_clk) disable iff (i_rst)
        (state_r == ST_SHIFT && edges.rise) |-> $stable(o_data))
        else $error("data moved at shift clock rise");
    AST_CNT_STEP: assert property ( // (R4)
        @(posedge i_clk) disable iff (i_rst)
        (state_r == ST_SHIFT && edges.rise) |=> cnt_r == $past(cnt_r) + 1'b1)
        else $error("bit count did not step on rise");
    AST_OE_ONLY_BY_WRITE: assert property ( // (R3)
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_clock_oe) |-> $past(i_osc_en_wr && i_osc_en_val))
        else $error("clock pin driven without enable write");
    AST_RESET_INPUT: assert property ( // (R2)
        @(posedge i_clk)
        (i_rst && !i_suspend) |=> !o_clock_oe)
        else $error("clock pin driven after reset");
    AST_START_ON_CHANGE: assert property ( // (R6)
        @(posedge i_clk) disable iff (i_rst)
        (state_r == ST_IDLE && pend_r && req_r != sent_r) |=> state_r == ST_SHIFT)
        else $error("changed request did not start a frame");
    AST_SUSPEND_KEEP: assert property ( // (R7)
        @(posedge i_clk)
        (i_rst && i_suspend && !i_osc_en_wr) |=> $stable(osc_en_r))
        else $error("suspend did not preserve enable bit");
endmodule

// [verif/pwr_sw_model.sv]
// behavioural dual socket power switch
`timescale 1ns/10ps
module pwr_sw_model
    import pwr_switch_pkg::*;
(
    input  wire logic              i_pin,
    input  wire logic              i_data,
    input  wire logic              i_latch,
    output logic [FRAME_BITS-1:0]  o_word,
    output logic [CNT_W-1:0]       o_bits
);
    logic [FRAME_BITS-1:0] sh_r;
    logic [CNT_W-1:0]      cnt_r;
    initial begin
        o_word = '0;
        o_bits = '0;
        sh_r = '0;
        cnt_r = '0;
    end
    always @(posedge i_pin) begin
        sh_r  <= {sh_r[FRAME_BITS-2:0], i_data};
        cnt_r <= cnt_r + 4'h1;
    end
    // outputs change only on latch, never while bits arrive
    always @(posedge i_latch) begin
        o_word <= sh_r;
        o_bits <= cnt_r;
        cnt_r  <= '0;
    end
endmodule

// [verif/tb_top.sv]
// self-checking bench for the power switch serial port
`timescale 1ns/10ps
module tb_top;
    import pwr_switch_pkg::*;
    logic                   i_clk, i_rst, i_suspend, i_osc_en_wr, i_osc_en_val;
    logic [SOCKET_BITS-1:0] i_sock_a, i_sock_b;
    logic                   o_clock_out, o_clock_oe, o_data, o_latch, o_busy;
    logic                   ext_clk, i_clock_in;
    logic [FRAME_BITS-1:0]  word;
    logic [CNT_W-1:0]       bits;
    int                     n_errors, cmp_count;
    // pin mux: reads o_clock_out while o_clock_oe is set, else the external source ext_clk
    assign i_clock_in = o_clock_oe ? o_clock_out : ext_clk;
    pwr_switch_port pwr_switch_port_inst (.i_clk, .i_rst, .i_suspend, .i_osc_en_wr,
        .i_osc_en_val, .i_sock_a, .i_sock_b, .i_clock_in, .o_clock_out, .o_clock_oe,
        .o_data, .o_latch, .o_busy);
    pwr_sw_model pwr_sw_model_inst (.i_pin(i_clock_in), .i_data(o_data),
        .i_latch(o_latch), .o_word(word), .o_bits(bits));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    // external source runs only within frames, off phase from i_clk
    initial begin
        ext_clk = 1'b0;
        #13;
        forever #160 ext_clk = (o_busy === 1'b1 && o_clock_oe !== 1'b1) ? ~ext_clk : 1'b0;
    end
    // ***********************************************************
    // shared tasks
    // ***********************************************************
    task automatic print_verdict();
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_latch();
        int k;
        for (k = 0; k < 3000 && o_latch !== 1'b1; k++)
            @(negedge i_clk);
        if (k == 3000) begin
            n_errors++;
            print_verdict();
        end
        @(negedge i_clk);
    endtask
    task automatic send(input logic [7:0] v);
        @(posedge i_clk);
        i_sock_b <= v[7:4];
        i_sock_a <= v[3:0];
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        chk("busy in frame", 8'h01, 8'(o_busy));
        wait_latch();
        chk("busy after frame", 8'h00, 8'(o_busy));
        chk("frame word", v, word);
        chk("rises per frame", 8'(FRAME_BITS), 8'(bits));
    endtask
    task automatic pulse_rst(input logic susp, input logic exp_oe);
        @(posedge i_clk);
        i_suspend <= susp;
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        @(negedge i_clk);
        chk("clock drive", 8'(exp_oe), 8'(o_clock_oe));
    endtask
    // ***********************************************************
    // scenarios
    // ***********************************************************
    task automatic t_change_mid();
        @(posedge i_clk);
        i_sock_b <= 4'h3;
        i_sock_a <= 4'hc;
        repeat (10) @(posedge i_clk);
        i_sock_b <= 4'hc;
        i_sock_a <= 4'h3;
        wait_latch();
        chk("first frame", 8'h3c, word);
        wait_latch();
        chk("pending frame", 8'hc3, word);
    endtask
    task automatic t_osc();
        @(posedge i_clk);
        i_osc_en_wr <= 1'b1;
        i_osc_en_val <= 1'b1;
        @(posedge i_clk);
        i_osc_en_wr <= 1'b0;
        @(negedge i_clk);
        chk("clock drive", 8'h01, 8'(o_clock_oe));
        send(8'h96);
        send(8'h69);
    endtask
    initial begin
        n_errors = 0;
        cmp_count = 0;
        i_rst = 1'b1;
        i_suspend = 1'b0;
        i_osc_en_wr = 1'b0;
        i_osc_en_val = 1'b0;
        i_sock_a = 4'h0;
        i_sock_b = 4'h0;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        @(negedge i_clk);
        chk("clock drive", 8'h00, 8'(o_clock_oe));
        chk("latch idle", 8'h00, 8'(o_latch));
        send(8'ha5);
        send(8'h5a);
        send(8'hff);
        send(8'h00);
        t_change_mid();
        t_osc();
        pulse_rst(1'b1, 1'b1);
        send(8'h18);
        pulse_rst(1'b0, 1'b0);
        // a full reset forgets what was sent, so the standing request goes out again
        wait_latch();
        chk("frame after reset", 8'h18, word);
        send(8'h81);
        print_verdict();
    end
endmodule
